// ---- core/bmx_map.svh ----
`ifndef BMX_MAP_SVH
`define BMX_MAP_SVH

// Register byte offsets on the control bus.
`define BMX_OFF_CTRL      8'h00
`define BMX_OFF_BASE      8'h04
`define BMX_OFF_LENGTH    8'h08
`define BMX_OFF_STATUS    8'h0C

// Field positions.
`define BMX_CTRL_GO       0
`define BMX_CTRL_FIXED    1
`define BMX_STAT_DONE     0
`define BMX_STAT_EARLY    1
`define BMX_STAT_BUSY     2

// Reset values and default sizes.
`define BMX_RST_WORD      32'h0000_0000
`define BMX_ADDR_BITS     32
`define BMX_WORD_BITS     32
`define BMX_FIFO_DEPTH    8
`define BMX_READ_VARIANT  1

`endif

// ---- core/bmx_pkg.sv ----
package bmx_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_issue,
    st_wait
  } bmx_state_t;

endpackage

// ---- core/bmx_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface bmx_fifo_if #(
  parameter int WIDTH = 32
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport feed  (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
  modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

`default_nettype wire

// ---- core/bmx_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

module bmx_mem
  import bmx_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
)(
  // Clock
  input  wire logic             clk,
  input  wire logic             ce,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      cells[waddr] <= wdata;
    end
  end

  // The bypass lets a word written into an empty buffer show up one cycle later.
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      rdata <= (we && waddr == raddr) ? wdata : cells[raddr];
    end
  end

endmodule

`default_nettype wire

// ---- core/bmx_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "bmx_map.svh"

module bmx_fifo
  import bmx_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = `BMX_FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Both sides of the buffer
  bmx_fifo_if.store port
);

  // Depth must be a power of two so the pointers wrap by themselves.
  localparam int AW = $clog2(DEPTH);

  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          full;
  logic          not_empty;
  logic          push;
  logic          pop;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0]   next_count;

  assign push        = port.push_valid && !full;
  assign pop         = port.pop_ready && not_empty;
  assign next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);

  assign port.push_ready = !full;
  assign port.pop_valid  = not_empty;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      full      <= 1'b0;
      not_empty <= 1'b0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      full      <= next_count == (AW+1)'(DEPTH);
      not_empty <= next_count != '0;
    end
  end

  bmx_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (push),
    .waddr (wr_ptr),
    .wdata (port.push_data),
    .raddr (next_rd_ptr),
    .rdata (port.pop_data)
  );

endmodule

`default_nettype wire

// ---- core/bmx_engine.sv ----
// What this block does
// [RQ1] With the fixed option captured, every bus access uses the same start address.
// [RQ2] Start address is a word aligned byte address; the transfer begins there.
// [RQ3] Software gives length in bytes, a whole multiple of the word size.
// [RQ4] The start strobe lasts one cycle and captures fixed, address and length.
// [RQ5] Completion rises and holds after the last write ack or last read return.
// [RQ6] A new start is taken from the cycle after completion rises.
// [RQ7] Read variant only: early completion rises when the last read is issued.
// [RQ8] Start address and length are addr_bits_param bits wide.
// [RQ9] Read variant: data output shows the oldest buffered word while data is present.
// [RQ10] Read variant: data-present is high exactly while the buffer holds a word.
// [RQ11] User never acknowledges a read while data-present is low.
// [RQ12] After a read acknowledge the next buffered word shows on the following cycle.
// [RQ13] User data ports are word_bits_param bits wide.
// [RQ14] Write variant: user offers words with the qualifier only while not full.
// [RQ15] Write variant: buffer-full is high whenever the buffer cannot take a word.
// [RQ16] Write variant: each qualified cycle pushes one word; none while full.
// [RQ17] Without the fixed option the address steps by the word size per word.
// [RQ18] Reset clears completion, empties the buffer and leaves the engine idle.
`timescale 1ns/1ps
`default_nettype none

`include "bmx_map.svh"

module bmx_engine
  import bmx_pkg::*;
#(
  parameter int addr_bits_param = `BMX_ADDR_BITS,
  parameter int word_bits_param = `BMX_WORD_BITS,
  parameter int fifo_depth      = `BMX_FIFO_DEPTH,
  parameter bit read_variant    = `BMX_READ_VARIANT
)(
  // Clock, reset and clock enable
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         ce,
  // Register bus slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // Memory bus master
  output logic                              mem_cyc_o,
  output logic                              mem_stb_o,
  output logic                              mem_we_o,
  output logic      [addr_bits_param-1:0]   mem_adr_o,
  output logic      [word_bits_param/8-1:0] mem_sel_o,
  output logic      [word_bits_param-1:0]   mem_dat_o,
  input  wire logic [word_bits_param-1:0]   mem_dat_i,
  input  wire logic                         mem_ack_i,
  // User data port, read variant
  input  wire logic                         user_read_ack,
  output logic      [word_bits_param-1:0]   user_data_out,
  output logic                              user_data_avail,
  // User data port, write variant
  input  wire logic                         user_write_valid,
  input  wire logic [word_bits_param-1:0]   user_data_in,
  output logic                              user_buffer_full,
  // Completion
  output logic                              done,
  output logic                              early_done
);

  localparam int                   A    = addr_bits_param;
  localparam int                   W    = word_bits_param;
  localparam int                   LOWB = $clog2(W / 8);
  localparam logic [A-1:0]         STEP = A'(W / 8);

  bmx_fifo_if #(.WIDTH(W)) buf_if ();

  bmx_state_t   state;
  logic [A-1:0] base_reg;
  logic [A-1:0] length_reg;
  logic         fixed_reg;
  logic         run_fixed;
  logic [A-1:0] cur_addr;
  logic [A-1:0] remaining;
  logic         wb_req;
  logic         wb_wr;
  logic         go;
  logic         go_fixed;
  logic         can_issue;
  logic         last_word;
  logic         bus_done;

  function automatic logic [31:0] bmx_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Register bus: a write takes effect on the edge where ack is high.
  assign wb_req   = wb_cyc_i && wb_stb_i;
  assign wb_wr    = wb_req && wb_we_i && wb_ack_o;
  assign go       = wb_wr && wb_adr_i == `BMX_OFF_CTRL && wb_sel_i[0]
                    && wb_dat_i[`BMX_CTRL_GO] && state == st_idle; // [RQ4] [RQ6]
  assign go_fixed = wb_dat_i[`BMX_CTRL_FIXED];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
    end
    else if (ce)
    begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      base_reg   <= A'(`BMX_RST_WORD);
      length_reg <= A'(`BMX_RST_WORD);
      fixed_reg  <= 1'b0;
    end
    else if (ce && wb_wr)
    begin
      if (wb_adr_i == `BMX_OFF_CTRL)
      begin
        if (wb_sel_i[0])
        begin
          fixed_reg <= go_fixed;
        end
      end
      else if (wb_adr_i == `BMX_OFF_BASE)
      begin
        base_reg <= A'(bmx_merge(32'(base_reg), wb_dat_i, wb_sel_i)); // [RQ8]
      end
      else if (wb_adr_i == `BMX_OFF_LENGTH)
      begin
        length_reg <= A'(bmx_merge(32'(length_reg), wb_dat_i, wb_sel_i)); // [RQ8]
      end
    end
  end

  // Unmapped offsets are acknowledged and read as zero.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_dat_o <= `BMX_RST_WORD;
    end
    else if (ce)
    begin
      wb_dat_o <= `BMX_RST_WORD;
      if (wb_adr_i == `BMX_OFF_CTRL)
      begin
        wb_dat_o[`BMX_CTRL_FIXED] <= fixed_reg;
      end
      else if (wb_adr_i == `BMX_OFF_BASE)
      begin
        wb_dat_o <= 32'(base_reg);
      end
      else if (wb_adr_i == `BMX_OFF_LENGTH)
      begin
        wb_dat_o <= 32'(length_reg);
      end
      else if (wb_adr_i == `BMX_OFF_STATUS)
      begin
        wb_dat_o[`BMX_STAT_DONE]  <= done;
        wb_dat_o[`BMX_STAT_EARLY] <= early_done;
        wb_dat_o[`BMX_STAT_BUSY]  <= state != st_idle;
      end
    end
  end

  // A length below one word is treated as the final word, so a bad length cannot hang the engine.
  assign last_word = remaining <= STEP; // [RQ3]
  assign can_issue = read_variant ? buf_if.push_ready : buf_if.pop_valid;
  assign bus_done  = state == st_wait && mem_ack_i;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= st_idle; // [RQ18]
    end
    else if (ce)
    begin
      case (state)
        st_idle:
        begin
          if (go && length_reg != '0)
          begin
            state <= st_issue;
          end
        end
        st_issue:
        begin
          if (can_issue)
          begin
            state <= st_wait;
          end
        end
        st_wait:
        begin
          if (mem_ack_i)
          begin
            state <= last_word ? st_idle : st_issue;
          end
        end
        default:
        begin
          state <= st_idle;
        end
      endcase
    end
  end

  // Transfer bookkeeping: captured start values, address and bytes left.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur_addr  <= '0;
      remaining <= '0;
      run_fixed <= 1'b0;
    end
    else if (ce)
    begin
      if (go)
      begin
        cur_addr  <= {base_reg[A-1:LOWB], LOWB'(0)}; // [RQ2] [RQ4]
        remaining <= length_reg; // [RQ4]
        run_fixed <= go_fixed; // [RQ4]
      end
      else if (bus_done)
      begin
        remaining <= remaining - STEP;
        if (!run_fixed)
        begin
          cur_addr <= cur_addr + STEP; // [RQ17]
        end
      end
    end
  end

  // Memory bus master: classic cycle held until ack.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mem_cyc_o <= 1'b0;
      mem_stb_o <= 1'b0;
      mem_we_o  <= 1'b0;
      mem_adr_o <= '0;
      mem_sel_o <= '0;
      mem_dat_o <= '0;
    end
    else if (ce)
    begin
      mem_sel_o <= '1;
      if (state == st_issue && can_issue)
      begin
        mem_cyc_o <= 1'b1;
        mem_stb_o <= 1'b1;
        mem_we_o  <= !read_variant;
        mem_adr_o <= cur_addr; // [RQ1]
        mem_dat_o <= buf_if.pop_data;
      end
      else if (bus_done)
      begin
        mem_cyc_o <= 1'b0;
        mem_stb_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      done       <= 1'b0; // [RQ18]
      early_done <= 1'b0; // [RQ18]
    end
    else if (ce)
    begin
      if (go)
      begin
        done       <= length_reg == '0;
        early_done <= read_variant && length_reg == '0;
      end
      else
      begin
        if (bus_done && last_word)
        begin
          done <= 1'b1; // [RQ5]
        end
        if (read_variant && state == st_issue && can_issue && last_word)
        begin
          early_done <= 1'b1; // [RQ7]
        end
      end
    end
  end

  // Buffer steering. Reads are only issued with room, so a returning word always fits.
  assign buf_if.push_valid = read_variant ? bus_done : user_write_valid; // [RQ16]
  assign buf_if.push_data  = read_variant ? mem_dat_i : user_data_in; // [RQ13]
  assign buf_if.pop_ready  = read_variant ? user_read_ack
                                          : (state == st_issue && can_issue); // [RQ12]

  // Misused strobes are ignored by the buffer: no underflow, and words offered while full are dropped.
  assign user_data_out    = read_variant ? buf_if.pop_data : '0; // [RQ9] [RQ13]
  assign user_data_avail  = read_variant ? buf_if.pop_valid : 1'b0; // [RQ10]
  assign user_buffer_full = read_variant ? 1'b0 : !buf_if.push_ready; // [RQ15]

  bmx_fifo #(
    .WIDTH (W),
    .DEPTH (fifo_depth)
  ) u_fifo (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .port  (buf_if.store)
  );

endmodule

`default_nettype wire

// ---- dv/bmx_engine_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module bmx_engine_sva
  import bmx_pkg::*;
#(
  parameter int addr_bits_param = 32,
  parameter int word_bits_param = 32,
  parameter bit read_variant    = 1'b1
)(
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // Register bus
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [7:0]                 wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic                       wb_ack_o,
  // Memory bus
  input wire logic                       mem_stb_o,
  input wire logic                       mem_we_o,
  input wire logic [addr_bits_param-1:0] mem_adr_o,
  input wire logic                       mem_ack_i,
  // User side and completion
  input wire logic                       user_read_ack,
  input wire logic [word_bits_param-1:0] user_data_out,
  input wire logic                       user_data_avail,
  input wire logic                       done,
  input wire logic                       early_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic go_edge;
  // The start write takes effect at the edge where the slave acknowledges it.
  assign go_edge = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[0];

  ack_pulse_a:     assert property (wb_ack_o |=> !wb_ack_o) else $error("register ack longer than one cycle");
  ack_answer_a:    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("register ack late");
  mem_hold_a:      assert property (mem_stb_o && !mem_ack_i |=> mem_stb_o && $stable(mem_adr_o))
    else $error("memory request changed before ack");
  mem_drop_a:      assert property (mem_stb_o && mem_ack_i |=> !mem_stb_o) else $error("memory request kept after ack");
  done_hold_a:     assert property (done && !go_edge |=> done) else $error("completion dropped");
  early_first_a:   assert property ($rose(done) |-> early_done == read_variant)
    else $error("early completion missing");
  early_issue_a:   assert property ($rose(early_done) |-> mem_stb_o || done)
    else $error("early completion unprompted");
  head_hold_a:     assert property (
    user_data_avail && !user_read_ack |=> user_data_avail && $stable(user_data_out))
    else $error("head word changed without a pop");
  bus_quiet_a:     assert property (mem_stb_o |-> !done && mem_we_o == !read_variant)
    else $error("bus access while complete");
  reset_clear_a:   assert property (
    $fell(reset) |-> !done && !early_done && !user_data_avail && !mem_stb_o)
    else $error("state not cleared by reset");

  cover property ($rose(done));
  cover property (mem_stb_o && mem_ack_i);
  cover property (user_read_ack && user_data_avail);
endmodule

`default_nettype wire

// ---- dv/bmx_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module bmx_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Request from the engine, and the answer delay from the testbench
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic [31:0] adr,
  input  wire logic [3:0]  delay,
  // Answer
  output logic             ack,
  output logic [31:0]      dat
);
  logic [3:0] wait_cnt;

  // Outside an answer the data lines toggle, so a stale word is never mistaken for fresh data.
  always_ff @(posedge clk)
  begin
    ack <= 1'b0;
    dat <= reset ? 32'h0000_0000 : ~dat;
    if (reset || !(cyc && stb) || ack)
      wait_cnt <= 4'h0;
    else if (wait_cnt >= delay)
    begin
      ack <= 1'b1;
      dat <= adr ^ 32'h5A5A_0000;
    end
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "bmx_map.svh"

module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mem_cyc_o;
  logic        mem_stb_o;
  logic        mem_we_o;
  logic [31:0] mem_adr_o;
  logic [3:0]  mem_sel_o;
  logic [31:0] mem_dat_o;
  logic [31:0] mem_dat_i;
  logic        mem_ack_i;
  logic [3:0]  mem_delay = 4'h0;
  logic        user_read_ack = 1'b0;
  logic [31:0] user_data_out;
  logic        user_data_avail;
  logic        user_buffer_full;
  logic        done;
  logic        early_done;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic        w_valid = 1'b0;
  logic [31:0] w_data = 32'h0000_0000;
  logic        w_cyc;
  logic        w_stb;
  logic        w_we;
  logic [31:0] w_adr;
  logic [31:0] w_wdat;
  logic        w_ack;
  logic        w_full;
  logic        w_done;
  logic        w_early;
  logic [31:0] w_base = 32'h0000_0000;
  logic        w_fixed = 1'b0;
  int          w_idx = 0;
  logic        saw_full = 1'b0;

  always #2 clk = ~clk;

  bmx_engine dut_u (.clk(clk), .reset(reset), .ce(1'b1), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mem_cyc_o(mem_cyc_o), .mem_stb_o(mem_stb_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o), .mem_sel_o(mem_sel_o),
    .mem_dat_o(mem_dat_o), .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i), .user_read_ack(user_read_ack),
    .user_data_out(user_data_out), .user_data_avail(user_data_avail), .user_write_valid(1'b0),
    .user_data_in(32'h0000_0000), .user_buffer_full(user_buffer_full), .done(done), .early_done(early_done));

  bmx_mem_model mem_u (.clk(clk), .reset(reset), .cyc(mem_cyc_o), .stb(mem_stb_o), .adr(mem_adr_o),
    .delay(mem_delay), .ack(mem_ack_i), .dat(mem_dat_i));

  // The write engine shares the register bus, so every start reaches both engines.
  bmx_engine #(.read_variant(1'b0)) dut_w_u (.clk(clk), .reset(reset), .ce(1'b1), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(),
    .wb_ack_o(), .mem_cyc_o(w_cyc), .mem_stb_o(w_stb), .mem_we_o(w_we), .mem_adr_o(w_adr), .mem_sel_o(),
    .mem_dat_o(w_wdat), .mem_dat_i(32'h0000_0000), .mem_ack_i(w_ack), .user_read_ack(1'b0), .user_data_out(),
    .user_data_avail(), .user_write_valid(w_valid), .user_data_in(w_data), .user_buffer_full(w_full),
    .done(w_done), .early_done(w_early));

  // A slow memory lets the write buffer fill up.
  bmx_mem_model mem_w_u (.clk(clk), .reset(reset), .cyc(w_cyc), .stb(w_stb), .adr(w_adr), .delay(4'hF),
    .ack(w_ack), .dat());

  always @(posedge clk)
  begin
    if (!reset && w_stb && w_ack)
    begin
      check(w_adr, w_fixed ? w_base : w_base + 32'(4 * w_idx));
      check(w_wdat, 32'hC3C3_0000 + 32'(w_idx));
      w_idx++;
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb_access(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  // A busy engine must ignore a second start, so the poked base must never show up.
  task automatic run_xfer(input logic [31:0] base, input int words, input logic fixed, input int stall, input bit poke);
    logic [31:0] q;
    w_base   = base;
    w_fixed  = fixed;
    w_idx    = 0;
    saw_full = 1'b0;
    wb_access(1'b1, `BMX_OFF_BASE, base, q);
    wb_access(1'b1, `BMX_OFF_LENGTH, 32'(words * 4), q);
    wb_access(1'b1, `BMX_OFF_CTRL, {30'h0, fixed, 1'b1}, q);
    if (poke)
    begin
      wb_access(1'b1, `BMX_OFF_BASE, 32'h0000_8000, q);
      wb_access(1'b1, `BMX_OFF_CTRL, 32'h0000_0001, q);
    end
    // A push every other cycle at most, so a full flag raised by the last push is seen before the next.
    for (int i = 0; i < words; i++)
    begin
      while (w_full !== 1'b0)
      begin
        saw_full = 1'b1;
        @(posedge clk);
      end
      w_data  <= 32'hC3C3_0000 + 32'(i);
      w_valid <= 1'b1;
      @(posedge clk);
      w_valid <= 1'b0;
      @(posedge clk);
    end
    repeat (stall) @(posedge clk);
    for (int i = 0; i < words; i++)
    begin
      while (user_data_avail !== 1'b1) @(posedge clk);
      check(user_data_out, (fixed ? base : base + 32'(4 * i)) ^ 32'h5A5A_0000);
      user_read_ack <= 1'b1;
      @(posedge clk);
      user_read_ack <= 1'b0;
      @(posedge clk);
    end
    while (done !== 1'b1 || w_done !== 1'b1) @(posedge clk);
    check({31'h0, user_data_avail}, 32'h0000_0000);
    check({31'h0, saw_full}, 32'(words > 8));
    check(32'(w_idx), 32'(words));
    check({30'h0, w_early, w_done}, 32'h0000_0001);
    wb_access(1'b0, `BMX_OFF_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0003);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [31:0] q;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wb_access(1'b0, `BMX_OFF_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    wb_access(1'b0, 8'h10, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    wb_access(1'b1, `BMX_OFF_CTRL, 32'h0000_0002, q);
    wb_access(1'b0, `BMX_OFF_CTRL, 32'h0000_0000, q);
    check(q, 32'h0000_0002);
    $display("test registers finished");
    run_xfer(32'h0000_0100, 10, 1'b0, 40, 1'b1);
    $display("test stepping with full buffer finished");
    mem_delay <= 4'h3;
    run_xfer(32'h0000_0200, 3, 1'b1, 0, 1'b0);
    $display("test fixed address finished");
    wb_access(1'b1, `BMX_OFF_LENGTH, 32'h0000_0000, q);
    wb_access(1'b1, `BMX_OFF_CTRL, 32'h0000_0001, q);
    while (done !== 1'b1) @(posedge clk);
    wb_access(1'b0, `BMX_OFF_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0003);
    check({31'h0, w_done}, 32'h0000_0001);
    $display("test empty length finished");
    wb_access(1'b1, `BMX_OFF_LENGTH, 32'h0000_0010, q);
    wb_access(1'b1, `BMX_OFF_CTRL, 32'h0000_0001, q);
    repeat (6) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({28'h0, w_full, w_done, done, user_data_avail}, 32'h0000_0000);
    wb_access(1'b0, `BMX_OFF_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    $display("test reset mid transfer finished");
    report_and_stop();
  end
endmodule

bind bmx_engine bmx_engine_sva #(.addr_bits_param(addr_bits_param), .word_bits_param(word_bits_param),
  .read_variant(read_variant)) sva_u (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .mem_stb_o(mem_stb_o), .mem_we_o(mem_we_o),
  .mem_adr_o(mem_adr_o), .mem_ack_i(mem_ack_i), .user_read_ack(user_read_ack), .user_data_out(user_data_out),
  .user_data_avail(user_data_avail), .done(done), .early_done(early_done));

`default_nettype wire
